/* rtl/status_privilege_control.sv */
// status register, kernel/user + interrupt-enable stack, privilege checks
// assumes synchronous inputs, one clock, exception and return strobes one cycle
`timescale 1ns/1ps
// Behaviour
// - bit 0 enables interrupts; when clear nothing is accepted.
// - bit 1 is current mode: zero kernel, one user.
// - bits 2-3 previous pair, bits 4-5 old pair; three-slot stack.
// - push the stack on every exception taken.
// - push moves prev to old, cur to prev, clears cur pair.
// - pop on return: old to prev, prev to cur.
// - mask bits 8-15; line i accepted only with mask bit i set.
// - bit 22 selects bootstrap (1) or runtime (0) handlers.
// - bit 27 enables the local timer.
// - bits 28-31 coprocessor usable; only bit 0 writable, rest zero.
// - coprocessor op with clear usable bit raises coprocessor unusable.
// - kernel mode always may use the control coprocessor.
// - all status fields except fixed usable bits are read/write.
// - addresses below 0x80000000 accessible only in kernel mode.
// - addresses 0x80000000 upward accessible in both modes.
// - user access below 0x80000000 raises address error.
module status_privilege_control #(
    parameter int NUM_LINES = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    // register port
    input wire status_pkg::reg_req_t req,
    output logic [31:0] rdata,
    // processor events
    input wire logic exc_take,
    input wire logic exc_return,
    input wire logic [NUM_LINES-1:0] irq_lines,
    input wire logic cop_access,
    input wire logic [1:0] cop_num,
    input wire logic mem_access,
    input wire logic [31:0] mem_addr,
    // control outputs
    output logic irq_accept,
    output logic boot_vector_select,
    output logic local_timer_enable,
    output logic cur_kernel_user_mode,
    output status_pkg::fault_t fault,
    output logic irq
);
    import status_pkg::*;

    // ========================================
    // state
    logic [31:0] status_q, status_d;
    logic [EV_NUM-1:0] ev_q, ev_d, evmask_q, evmask_d;
    logic [31:0] rdata_d;
    logic accept_d, cpu_d, ade_d, irq_d;
    logic [NUM_LINES-1:0] masked;
    logic [KU_OLD_POS:IE_CUR_POS] stk;

    // per-line gating by the mask
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
            assign masked[gi] = irq_lines[gi] & status_q[MASK_LO_POS + gi];
        end
    endgenerate

    // next status: software write first, then hardware push/pop on top
    always_comb begin
        status_d = status_q;
        if (req.wr && req.addr == STATUS_ADDR) begin
            status_d = req.wdata & STATUS_WMASK;
        end
        stk = status_d[KU_OLD_POS:IE_CUR_POS];
        if (exc_take) begin
            stk = {status_d[KU_PREV_POS], status_d[IE_PREV_POS],
                   status_d[KU_CUR_POS], status_d[IE_CUR_POS], 2'b00};
        end else if (exc_return) begin
            stk = {status_d[KU_OLD_POS], status_d[IE_OLD_POS],
                   status_d[KU_OLD_POS], status_d[IE_OLD_POS],
                   status_d[KU_PREV_POS], status_d[IE_PREV_POS]};
        end
        status_d[KU_OLD_POS:IE_CUR_POS] = stk;
    end

    // privilege checks and interrupt acceptance use the registered current slot
    always_comb begin
        accept_d = status_q[IE_CUR_POS] & (|masked);
        // kernel mode (bit clear) always owns coprocessor 0
        cpu_d = cop_access && !status_q[CU0_POS + 32'(cop_num)] &&
                !(cop_num == 2'h0 && !status_q[KU_CUR_POS]);
        ade_d = mem_access && status_q[KU_CUR_POS]
                && (mem_addr < USER_SEG_BASE);
    end

    // sticky events: set wins over write-one-to-clear
    always_comb begin
        ev_d = ev_q;
        evmask_d = evmask_q;
        if (req.wr && req.addr == IRQ_STAT_ADDR) begin
            ev_d = ev_q & ~req.wdata[EV_NUM-1:0];
        end
        if (req.wr && req.addr == IRQ_MASK_ADDR) begin
            evmask_d = req.wdata[EV_NUM-1:0];
        end
        ev_d[EV_EXC] = ev_d[EV_EXC] | exc_take;
        ev_d[EV_RET] = ev_d[EV_RET] | exc_return;
        ev_d[EV_CPU] = ev_d[EV_CPU] | cpu_d;
        ev_d[EV_ADE] = ev_d[EV_ADE] | ade_d;
        irq_d = |(ev_d & evmask_d);
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 32'h00000000;
        if (req.rd) begin
            case (req.addr)
                STATUS_ADDR: rdata_d = status_q;
                IRQ_STAT_ADDR: rdata_d = {{(32-EV_NUM){1'b0}}, ev_q};
                IRQ_MASK_ADDR: rdata_d = {{(32-EV_NUM){1'b0}}, evmask_q};
                PEND_ADDR: rdata_d = {{(32-NUM_LINES){1'b0}}, masked};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    // status word and its mirrors; the mirrors load the next value, not the
    // registered one, so they never trail what software reads back
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_q <= STATUS_RESET;
            boot_vector_select <= STATUS_RESET[BOOT_VEC_POS];
            local_timer_enable <= STATUS_RESET[TIMER_EN_POS];
            cur_kernel_user_mode <= STATUS_RESET[KU_CUR_POS];
        end else if (clk_en) begin
            status_q <= status_d;
            boot_vector_select <= status_d[BOOT_VEC_POS];
            local_timer_enable <= status_d[TIMER_EN_POS];
            cur_kernel_user_mode <= status_d[KU_CUR_POS];
        end
    end

    // sticky events, their mask and the level interrupt
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ev_q <= '0;
            evmask_q <= '0;
            irq <= 1'b0;
        end else if (clk_en) begin
            ev_q <= ev_d;
            evmask_q <= evmask_d;
            irq <= irq_d;
        end
    end

    // read data and per-cycle verdicts; a low clock enable holds them as well
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h00000000;
            irq_accept <= 1'b0;
            fault <= '0;
        end else if (clk_en) begin
            rdata <= rdata_d;
            irq_accept <= accept_d;
            fault.cop_unusable <= cpu_d;
            fault.addr_error <= ade_d;
        end
    end

    // ========================================
    // assertions
    sequence s_push;
        clk_en && exc_take && !(req.wr && req.addr == STATUS_ADDR);
    endsequence

    a_push_shift: assert property (@(posedge clock) disable iff (!resetn)
        s_push |=> status_q[5:0] == {$past(status_q[3:0]), 2'b00})
        else $error("stack push wrong");
    a_pop_shift: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && exc_return && !exc_take && !(req.wr && req.addr == STATUS_ADDR)
        |=> status_q[3:0] == $past(status_q[5:2]))
        else $error("stack pop wrong");
    a_cu_upper_zero: assert property (@(posedge clock) disable iff (!resetn)
        status_q[31:29] == 3'h0)
        else $error("upper usable bits set");
    a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
        (status_q & ~STATUS_WMASK) == 32'h0)
        else $error("reserved bit set");
    a_ie_gate: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && !status_q[IE_CUR_POS] |=> !irq_accept)
        else $error("interrupt accepted while disabled");
    a_kernel_cp0: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && cop_access && cop_num == 2'h0 && !status_q[KU_CUR_POS]
        |=> !fault.cop_unusable)
        else $error("cp0 refused in kernel");
    a_user_low: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && mem_access && status_q[KU_CUR_POS] && !mem_addr[31]
        |=> fault.addr_error)
        else $error("user low access not faulted");
    a_user_seg: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && mem_access && mem_addr[31] |=> !fault.addr_error)
        else $error("user segment faulted");
    a_write_back: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && req.wr && req.addr == STATUS_ADDR && !exc_take && !exc_return
        ##1 clk_en && req.rd && req.addr == STATUS_ADDR && !req.wr
        |=> rdata == ($past(req.wdata, 2) & STATUS_WMASK))
        else $error("status readback wrong");

    // ========================================
    // stack, mirror, gating, privilege, event, freeze and read-data checks
    sequence s_pop;
        clk_en && exc_return && !exc_take && !(req.wr && req.addr == STATUS_ADDR);
    endsequence

    sequence s_status_read;
        clk_en && req.rd && !req.wr && req.addr == STATUS_ADDR;
    endsequence

    // a line is raised, its mask bit is on and interrupts are enabled
    sequence s_accept_ready;
        clk_en && status_q[IE_CUR_POS]
        && |(irq_lines & status_q[MASK_LO_POS +: NUM_LINES]);
    endsequence

    // pop copies old into previous but leaves the old slot as it was
    a_pop_old_keep: assert property (@(posedge clock) disable iff (!resetn)
        s_pop |=> status_q[KU_OLD_POS:IE_OLD_POS] == $past(status_q[KU_OLD_POS:IE_OLD_POS]))
        else $error("pop disturbed the old slot");

    // a push lands in kernel mode with interrupts off, even beside a write
    a_push_kernel: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && exc_take |=> status_q[KU_CUR_POS:IE_CUR_POS] == 2'h0
        && !cur_kernel_user_mode)
        else $error("push left user mode or interrupts on");

    // the mode pin must never disagree with the word that software sees
    a_mode_mirror: assert property (@(posedge clock) disable iff (!resetn)
        cur_kernel_user_mode == status_q[KU_CUR_POS])
        else $error("mode output differs from status");

    // boot vector pin follows the status word from reset onward
    a_boot_mirror: assert property (@(posedge clock) disable iff (!resetn)
        boot_vector_select == status_q[BOOT_VEC_POS])
        else $error("boot vector output differs from status");

    // local timer enable pin follows the status word
    a_timer_mirror: assert property (@(posedge clock) disable iff (!resetn)
        local_timer_enable == status_q[TIMER_EN_POS])
        else $error("timer enable output differs from status");

    // the global enable and an unmasked raised line must lead to acceptance
    a_accept_on: assert property (@(posedge clock) disable iff (!resetn)
        s_accept_ready |=> irq_accept)
        else $error("enabled unmasked interrupt not accepted");

    // with every raised line masked off nothing may be accepted
    a_mask_gate: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && !(|(irq_lines & status_q[MASK_LO_POS +: NUM_LINES])) |=> !irq_accept)
        else $error("masked interrupt accepted");

    // user code without usability bit 0 loses the coprocessor
    a_user_cop: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && cop_access && status_q[KU_CUR_POS] && !status_q[CU0_POS]
        |=> fault.cop_unusable)
        else $error("unusable coprocessor not faulted");

    // coprocessors 1 to 3 are absent, so every attempt on them faults
    a_upper_cop: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && cop_access && cop_num != 2'h0 |=> fault.cop_unusable)
        else $error("absent coprocessor not faulted");

    // kernel mode reaches the low segments without a fault
    a_kernel_low: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && mem_access && !status_q[KU_CUR_POS] |=> !fault.addr_error)
        else $error("kernel access faulted");

    // a coprocessor fault pulse always leaves its sticky event behind
    a_cop_event: assert property (@(posedge clock) disable iff (!resetn)
        fault.cop_unusable |-> ev_q[EV_CPU])
        else $error("coprocessor fault without event");

    // an address error pulse always leaves its sticky event behind
    a_ade_event: assert property (@(posedge clock) disable iff (!resetn)
        fault.addr_error |-> ev_q[EV_ADE])
        else $error("address error without event");

    // a low clock enable must freeze the word and the acceptance verdict
    a_freeze_hold: assert property (@(posedge clock) disable iff (!resetn)
        !clk_en |=> $stable(status_q) && $stable(irq_accept))
        else $error("state moved while clock enable low");

    // an exception always leaves its sticky event, even beside a clear
    a_exc_sticky: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && exc_take |=> ev_q[EV_EXC])
        else $error("exception event lost");

    // read data stand for one cycle only and are zero otherwise
    a_read_idle: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && !req.rd |=> rdata == 32'h0)
        else $error("read data without a read");

    // reserved and absent bits never reach the read data
    a_read_reserved: assert property (@(posedge clock) disable iff (!resetn)
        s_status_read |=> (rdata & ~STATUS_WMASK) == 32'h0)
        else $error("reserved bit read back set");
endmodule // status_privilege_control

/* rtl/status_pkg.sv */
// package for the processor status/privilege register block
// assumes a single 250 MHz clock domain and a plain register port
package status_pkg;
    // ========================================
    // register map
    localparam logic [3:0] STATUS_ADDR = 4'h0;
    localparam logic [3:0] IRQ_STAT_ADDR = 4'h4;
    localparam logic [3:0] IRQ_MASK_ADDR = 4'h8;
    localparam logic [3:0] PEND_ADDR = 4'hC;
    // ========================================
    // status field positions
    localparam int IE_CUR_POS = 0;
    localparam int KU_CUR_POS = 1;
    localparam int IE_PREV_POS = 2;
    localparam int KU_PREV_POS = 3;
    localparam int IE_OLD_POS = 4;
    localparam int KU_OLD_POS = 5;
    localparam int MASK_LO_POS = 8;
    localparam int BOOT_VEC_POS = 22;
    localparam int TIMER_EN_POS = 27;
    localparam int CU0_POS = 28;
    // writable bits: stack, mask, boot vector, timer enable, cu0 only
    localparam logic [31:0] STATUS_WMASK = 32'h1840FF3F;
    localparam logic [31:0] STATUS_RESET = 32'h00400000;
    localparam logic [31:0] USER_SEG_BASE = 32'h80000000;
    // event bits of the interrupt status register
    localparam int EV_EXC = 0;
    localparam int EV_RET = 1;
    localparam int EV_CPU = 2;
    localparam int EV_ADE = 3;
    localparam int EV_NUM = 4;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic cop_unusable;
        logic addr_error;
    } fault_t;
endpackage

/* verification/status_privilege_control_bench.sv */
// self-checking bench for the status/privilege register block
// assumes the status_pkg register map and one 250 MHz clock
`timescale 1ns/1ps
module status_privilege_control_bench;
    import status_pkg::*;
    logic clock = 0, resetn = 0, exc_take = 0, exc_return = 0, cop_access = 0, mem_access = 0;
    logic clk_en = 1'b1;
    reg_req_t req = '0;
    logic [7:0] irq_lines = '0;
    logic [1:0] cop_num = '0;
    logic [31:0] mem_addr = '0, rdata, s, w, a;
    logic irq_accept, boot_vector_select, local_timer_enable, cur_kernel_user_mode, irq;
    fault_t fault;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    // clock enable stays high except in the freeze scenario at the end
    status_privilege_control #(.NUM_LINES(8)) status_privilege_control_inst (
        .clock(clock), .resetn(resetn), .clk_en(clk_en), .req(req), .rdata(rdata),
        .exc_take(exc_take), .exc_return(exc_return), .irq_lines(irq_lines),
        .cop_access(cop_access), .cop_num(cop_num), .mem_access(mem_access),
        .mem_addr(mem_addr), .irq_accept(irq_accept), .boot_vector_select(boot_vector_select),
        .local_timer_enable(local_timer_enable), .cur_kernel_user_mode(cur_kernel_user_mode),
        .fault(fault), .irq(irq));
    // ==========================================
    // clock, timeout and helpers
    initial forever #2 clock = ~clock;
    // ceiling well above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bus cycles: strobe one cycle, released at the sampling edge
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clock) req <= '{1'b1, 1'b0, ad, d};
        @(posedge clock) req <= '0;
        #1;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [31:0] d);
        @(posedge clock) req <= '{1'b0, 1'b1, ad, 32'h0};
        @(posedge clock) req <= '0;
        #1 d = rdata;
    endtask
    // one-cycle event pulse: bit3 exception, bit2 return, bit1 cop, bit0 mem
    task automatic pulse(input logic [3:0] k);
        @(posedge clock) {exc_take, exc_return, cop_access, mem_access} <= k;
        @(posedge clock) {exc_take, exc_return, cop_access, mem_access} <= 4'h0;
        #1;
    endtask
    function automatic logic [31:0] push(input logic [31:0] v);
        return {v[31:6], v[3:0], 2'b00};
    endfunction
    // pop leaves the old pair in place
    function automatic logic [31:0] pop(input logic [31:0] v);
        return {v[31:6], v[5:4], v[5:2]};
    endfunction
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h31789E04));
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rd(STATUS_ADDR, s);
        chk(s, STATUS_RESET);
        chk(boot_vector_select, STATUS_RESET[BOOT_VEC_POS]);
        rd(4'h2, s);
        chk(s, 32'h0);
        // status fields, mirrors, push and pop
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom;
            wr(STATUS_ADDR, w);
            chk({boot_vector_select, local_timer_enable}, {w[22], w[27]});
            chk(cur_kernel_user_mode, w[1]);
            rd(STATUS_ADDR, s);
            chk(s, w & STATUS_WMASK);
            pulse(4'h8);
            rd(STATUS_ADDR, s);
            chk(s, push(w & STATUS_WMASK));
            chk(cur_kernel_user_mode, 1'b0);
            pulse(4'h4);
            rd(STATUS_ADDR, s);
            chk(s, pop(push(w & STATUS_WMASK)));
        end
        // write then read with no gap between the strobes
        w = $urandom;
        @(posedge clock) req <= '{1'b1, 1'b0, STATUS_ADDR, w};
        @(posedge clock) req <= '{1'b0, 1'b1, STATUS_ADDR, 32'h0};
        @(posedge clock) req <= '0;
        #1 chk(rdata, w & STATUS_WMASK);
        // acceptance from enable, mask and lines; first case all lines but disabled
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 32'h00FFFF00 : $urandom;
            @(posedge clock) irq_lines <= w[23:16];
            wr(STATUS_ADDR, w & 32'h0000FF01);
            @(posedge clock) #1;
            chk(irq_accept, w[0] & |(w[23:16] & w[15:8]));
            rd(PEND_ADDR, s);
            chk(s, {24'h0, w[23:16] & w[15:8]});
        end
        // privilege checks, boundary addresses first
        for (int i = 0; i < 12; i++) begin
            w = $urandom;
            if (i < 3)
                w = (w & ~32'h10000030) | 32'h2;
            a = (i == 0) ? 32'h7FFFFFFF : (i == 1) ? USER_SEG_BASE : $urandom;
            @(posedge clock) mem_addr <= a;
            cop_num <= w[5:4];
            wr(STATUS_ADDR, w & 32'h10000002);
            wr(IRQ_STAT_ADDR, 32'hF);
            pulse(4'h3);
            chk(fault.addr_error, w[1] & ~a[31]);
            chk(fault.cop_unusable, (w[5:4] != 2'h0) | (w[1] & ~w[28]));
            rd(IRQ_STAT_ADDR, s);
            chk(s, {28'h0, w[1] & ~a[31], (w[5:4] != 2'h0) | (w[1] & ~w[28]), 2'h0});
        end
        // sticky event, mask and write-one-to-clear
        wr(IRQ_MASK_ADDR, 32'h0);
        wr(IRQ_STAT_ADDR, 32'hF);
        pulse(4'h8);
        rd(IRQ_STAT_ADDR, s);
        chk(s, 32'h1);
        chk(irq, 1'b0);
        wr(IRQ_MASK_ADDR, 32'h1);
        @(posedge clock) #1;
        chk(irq, 1'b1);
        rd(IRQ_MASK_ADDR, s);
        chk(s, 32'h1);
        wr(IRQ_STAT_ADDR, 32'h1);
        @(posedge clock) #1;
        chk(irq, 1'b0);
        // clock enable low: a write and an exception must both be ignored
        wr(STATUS_ADDR, 32'h0);
        @(posedge clock) clk_en <= 1'b0;
        wr(STATUS_ADDR, 32'hFFFFFFFF);
        pulse(4'h8);
        @(posedge clock) clk_en <= 1'b1;
        rd(STATUS_ADDR, s);
        chk(s, 32'h0);
        chk(boot_vector_select, 1'b0);
        stop_test();
    end
endmodule // status_privilege_control_bench
